// ==== osc_setup_defs.svh ====
// Purpose: named offsets, field positions, reset values and codes
// Assumes: included by osc_setup_events.sv
// Notes: byte offsets on a 32-bit AHB-Lite register bus
`ifndef OSC_SETUP_DEFS_SVH
`define OSC_SETUP_DEFS_SVH
`define OFS_LS_TUNE 8'h00
`define OFS_HS_SETUP 8'h04
`define OFS_FLAGS 8'h08
`define OFS_FLAG_CLR 8'h0C
`define OFS_ENABLES 8'h10
`define OFS_TRIM_CTRL 8'h14
`define LS_CAP_LSB 8
`define LS_BOOST_LSB 6
`define LS_NORM_LSB 4
`define LS_WAIT_LSB 0
`define HS_FREQ_LSB 10
`define HS_TYPE_LSB 8
`define HS_GAIN_LSB 4
`define HS_WAIT_LSB 0
`define TRIM_BIT 4
`define EV_STOP 5
`define EV_TRIM 4
`define EV_HS 2
`define EV_LS 1
`define EV_INT 0
`define EV_MASK 6'h37
`define RST_LS_CAP 3'h0
`define RST_LS_BOOST 2'h2
`define RST_LS_NORM 2'h1
`define RST_LS_WAIT 2'h2
`define RST_HS_FREQ 2'h3
`define RST_HS_TYPE 2'h0
`define RST_HS_GAIN 2'h1
`define RST_HS_WAIT 3'h0
`define HS_TYPE_INTERNAL 2'h0
`define HS_TYPE_CR 2'h1
`define HS_TYPE_XTAL 2'h2
`define LS_WAIT_4K 17'h01000
`define HS_WAIT_BASE 17'h00004
`define HS_WAIT_CODE_MID 3'h6
`define HS_WAIT_CODE_LONG 3'h7
`define LS_WAIT_CODE_MID 2'h2
`define LS_WAIT_CODE_LONG 2'h3
`define LS_WAIT_CODE_SHORT 2'h1
`endif

// ==== osc_setup_pkg.sv ====
// Purpose: types shared by the oscillator setup block
// Assumes: nothing
// Notes: settle states are Gray coded along idle, count, done
package osc_setup_pkg;
  typedef enum logic [1:0] {
    SETTLE_IDLE = 2'b00,
    SETTLE_COUNT = 2'b01,
    SETTLE_DONE = 2'b11
  } settle_state_t;
  typedef logic [16:0] wait_count_t;
endpackage

// ==== osc_setup_events.sv ====
// Purpose: oscillator configuration registers, settle counters and event flags
// Assumes: AHB-Lite slave, zero wait states; analog strobes synchronous to clock_in
// Notes: oscillator ticks arrive as one-cycle enables from the analog side
// Notes on behaviour
// - three-bit low-speed gate capacitance code held and driven, 7 max, 0 min.
// - low-speed boost gain code drives the cell only while boost startup runs.
// - low-speed normal gain code drives the cell after startup.
// - low-speed settle wait 65536, 16384, 4096 ticks for codes 3, 2, 1.
// - internal type frequency code 3..0 selects 4 MHz, 2, 1, 0.5 MHz.
// - high-speed type code: 0 internal, 1 CR, 2 crystal; 3 reserved.
// - high-speed gain code applies only when crystal type is selected.
// - high-speed settle wait is four ticks times four to the code.
// - oscillation stop sets bit 5; trim completion sets bit 4.
// - settle done sets bit 2 high-speed, bit 1 low-speed, bit 0 internal.
// - writing one clears an event flag; writing zero leaves it.
// - internal settle flag reads zero after reset release.
// - enables for stop at bit 5 and trim done at bit 4.
// - enables for settle done at bits 2, 1 and 0.
// - trim start bit clears itself when trimming finishes, raising the flag.
`timescale 1ns/1ps
`include "osc_setup_defs.svh"
`default_nettype none
module osc_setup_events
  import osc_setup_pkg::*;
#(
  parameter wait_count_t LS_WAIT_MID = 17'h04000,
  parameter wait_count_t LS_WAIT_LONG = 17'h10000,
  parameter wait_count_t HS_WAIT_MID = 17'h04000,
  parameter wait_count_t HS_WAIT_LONG = 17'h10000
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // analog cell status
  input wire logic lowspeed_enable_in,
  input wire logic lowspeed_tick_in,
  input wire logic lowspeed_boost_active_in,
  input wire logic lowspeed_stop_in,
  input wire logic highspeed_enable_in,
  input wire logic highspeed_tick_in,
  input wire logic internal_settled_in,
  input wire logic trim_finished_in,
  // analog cell controls
  output logic [2:0] gate_cap_code_out,
  output logic [1:0] lowspeed_gain_out,
  output logic [1:0] highspeed_freq_select_out,
  output logic [1:0] highspeed_type_select_out,
  output logic [1:0] highspeed_xtal_gain_out,
  output logic lowspeed_stable_out,
  output logic highspeed_stable_out,
  output logic auto_trim_start_out,
  // interrupt
  output logic irq_out
);

  function automatic wait_count_t ls_target(input logic [1:0] code);
    unique case (code)
      `LS_WAIT_CODE_LONG: ls_target = LS_WAIT_LONG;
      `LS_WAIT_CODE_MID: ls_target = LS_WAIT_MID;
      default: ls_target = `LS_WAIT_4K;
    endcase
  endfunction

  function automatic wait_count_t hs_target(input logic [2:0] code);
    unique case (code)
      `HS_WAIT_CODE_LONG: hs_target = HS_WAIT_LONG;
      `HS_WAIT_CODE_MID: hs_target = HS_WAIT_MID;
      default: hs_target = wait_count_t'(`HS_WAIT_BASE << {code, 1'b0});
    endcase
  endfunction

  logic [2:0] gate_cap_code_q;
  logic [1:0] lowspeed_boost_gain_q;
  logic [1:0] lowspeed_normal_gain_q;
  logic [1:0] lowspeed_settle_wait_q;
  logic [1:0] highspeed_freq_select_q;
  logic [1:0] highspeed_type_select_q;
  logic [1:0] highspeed_xtal_gain_q;
  logic [2:0] highspeed_settle_wait_q;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [5:0] enables_q;
  logic auto_trim_start_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_ok;
  logic [15:0] rd_word;
  logic [5:0] ev_set;
  logic [5:0] ev_clr;
  logic wr_now;
  settle_state_t ls_state_q;
  settle_state_t hs_state_q;
  wait_count_t ls_cnt_q;
  wait_count_t hs_cnt_q;
  logic ls_en_q;
  logic hs_en_q;
  logic ls_done;
  logic hs_done;

  // bus: always ready, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;
  assign addr_ok = hsel_in && hready_in && htrans_in[1];
  assign wr_now = wr_pend_q;

  always_comb begin
    rd_word = 16'h0000;
    unique case (haddr_in)
      `OFS_LS_TUNE: begin
        rd_word[`LS_CAP_LSB +: 3] = gate_cap_code_q;
        rd_word[`LS_BOOST_LSB +: 2] = lowspeed_boost_gain_q;
        rd_word[`LS_NORM_LSB +: 2] = lowspeed_normal_gain_q;
        rd_word[`LS_WAIT_LSB +: 2] = lowspeed_settle_wait_q;
      end
      `OFS_HS_SETUP: begin
        rd_word[`HS_FREQ_LSB +: 2] = highspeed_freq_select_q;
        rd_word[`HS_TYPE_LSB +: 2] = highspeed_type_select_q;
        rd_word[`HS_GAIN_LSB +: 2] = highspeed_xtal_gain_q;
        rd_word[`HS_WAIT_LSB +: 3] = highspeed_settle_wait_q;
      end
      `OFS_FLAGS: rd_word[5:0] = flags_q & `EV_MASK;
      `OFS_ENABLES: rd_word[5:0] = enables_q & `EV_MASK;
      `OFS_TRIM_CTRL: rd_word[`TRIM_BIT] = auto_trim_start_q;
      default: rd_word = 16'h0000;
    endcase
  end

  // address phase capture, read data for the data phase
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      if (hready_in) begin
        wr_pend_q <= addr_ok && hwrite_in;
        wr_addr_q <= haddr_in;
      end
      if (addr_ok && !hwrite_in) begin
        hrdata_q <= {16'h0000, rd_word};
      end
    end
  end

  // low-speed tuning register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_cap_code_q <= `RST_LS_CAP;
      lowspeed_boost_gain_q <= `RST_LS_BOOST;
      lowspeed_normal_gain_q <= `RST_LS_NORM;
      lowspeed_settle_wait_q <= `RST_LS_WAIT;
    end else if (wr_now && wr_addr_q == `OFS_LS_TUNE) begin
      gate_cap_code_q <= hwdata_in[`LS_CAP_LSB +: 3];
      lowspeed_boost_gain_q <= hwdata_in[`LS_BOOST_LSB +: 2];
      lowspeed_normal_gain_q <= hwdata_in[`LS_NORM_LSB +: 2];
      lowspeed_settle_wait_q <= hwdata_in[`LS_WAIT_LSB +: 2];
    end
  end

  // high-speed setup register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      highspeed_freq_select_q <= `RST_HS_FREQ;
      highspeed_type_select_q <= `RST_HS_TYPE;
      highspeed_xtal_gain_q <= `RST_HS_GAIN;
      highspeed_settle_wait_q <= `RST_HS_WAIT;
    end else if (wr_now && wr_addr_q == `OFS_HS_SETUP) begin
      highspeed_freq_select_q <= hwdata_in[`HS_FREQ_LSB +: 2];
      highspeed_type_select_q <= hwdata_in[`HS_TYPE_LSB +: 2];
      highspeed_xtal_gain_q <= hwdata_in[`HS_GAIN_LSB +: 2];
      highspeed_settle_wait_q <= hwdata_in[`HS_WAIT_LSB +: 3];
    end
  end

  // analog controls
  assign gate_cap_code_out = gate_cap_code_q;
  assign lowspeed_gain_out = lowspeed_boost_active_in ?
                             lowspeed_boost_gain_q : lowspeed_normal_gain_q;
  assign highspeed_freq_select_out = highspeed_freq_select_q;
  assign highspeed_type_select_out = highspeed_type_select_q;
  assign highspeed_xtal_gain_out = (highspeed_type_select_q == `HS_TYPE_XTAL) ?
                                   highspeed_xtal_gain_q : 2'h0;
  assign lowspeed_stable_out = (ls_state_q == SETTLE_DONE);
  assign highspeed_stable_out = (hs_state_q == SETTLE_DONE);
  assign auto_trim_start_out = auto_trim_start_q;

  // low-speed settle counter, restarts on each enable rise
  assign ls_done = (ls_state_q == SETTLE_COUNT) && lowspeed_tick_in &&
                   (wait_count_t'(ls_cnt_q + 17'h00001) == ls_target(lowspeed_settle_wait_q));
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ls_state_q <= SETTLE_IDLE;
      ls_cnt_q <= 17'h00000;
      ls_en_q <= 1'b0;
    end else begin
      ls_en_q <= lowspeed_enable_in;
      if (!lowspeed_enable_in) begin
        ls_state_q <= SETTLE_IDLE;
      end else if (!ls_en_q) begin
        ls_state_q <= SETTLE_COUNT;
        ls_cnt_q <= 17'h00000;
      end else if (ls_done) begin
        ls_state_q <= SETTLE_DONE;
      end else if (ls_state_q == SETTLE_COUNT && lowspeed_tick_in) begin
        ls_cnt_q <= wait_count_t'(ls_cnt_q + 17'h00001);
      end
    end
  end

  // high-speed settle counter
  assign hs_done = (hs_state_q == SETTLE_COUNT) && highspeed_tick_in &&
                   (wait_count_t'(hs_cnt_q + 17'h00001) == hs_target(highspeed_settle_wait_q));
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hs_state_q <= SETTLE_IDLE;
      hs_cnt_q <= 17'h00000;
      hs_en_q <= 1'b0;
    end else begin
      hs_en_q <= highspeed_enable_in;
      if (!highspeed_enable_in) begin
        hs_state_q <= SETTLE_IDLE;
      end else if (!hs_en_q) begin
        hs_state_q <= SETTLE_COUNT;
        hs_cnt_q <= 17'h00000;
      end else if (hs_done) begin
        hs_state_q <= SETTLE_DONE;
      end else if (hs_state_q == SETTLE_COUNT && highspeed_tick_in) begin
        hs_cnt_q <= wait_count_t'(hs_cnt_q + 17'h00001);
      end
    end
  end

  // auto trim start bit
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      auto_trim_start_q <= 1'b0;
    end else if (trim_finished_in) begin
      auto_trim_start_q <= 1'b0;
    end else if (wr_now && wr_addr_q == `OFS_TRIM_CTRL) begin
      auto_trim_start_q <= hwdata_in[`TRIM_BIT];
    end
  end

  // event flags: set wins over clear
  always_comb begin
    ev_set = 6'h00;
    ev_set[`EV_STOP] = lowspeed_stop_in;
    ev_set[`EV_TRIM] = trim_finished_in && auto_trim_start_q;
    ev_set[`EV_HS] = hs_done;
    ev_set[`EV_LS] = ls_done;
    ev_set[`EV_INT] = internal_settled_in;
    ev_clr = 6'h00;
    if (wr_now && (wr_addr_q == `OFS_FLAGS || wr_addr_q == `OFS_FLAG_CLR)) begin
      ev_clr = hwdata_in[5:0] & `EV_MASK;
    end
    flags_d = ((flags_q & ~ev_clr) | ev_set) & `EV_MASK;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enables_q <= 6'h00;
    end else if (wr_now && wr_addr_q == `OFS_ENABLES) begin
      enables_q <= hwdata_in[5:0] & `EV_MASK;
    end
  end

  assign irq_out = |(flags_q & enables_q);

  // tick tallies kept apart from the settle counters, for the checks below
  wait_count_t ls_ticks_q;
  wait_count_t hs_ticks_q;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ls_ticks_q <= 17'h00000;
    end else if (!ls_en_q) begin
      ls_ticks_q <= 17'h00000;
    end else if (ls_state_q == SETTLE_COUNT && lowspeed_tick_in) begin
      ls_ticks_q <= wait_count_t'(ls_ticks_q + 17'h00001);
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hs_ticks_q <= 17'h00000;
    end else if (!hs_en_q) begin
      hs_ticks_q <= 17'h00000;
    end else if (hs_state_q == SETTLE_COUNT && highspeed_tick_in) begin
      hs_ticks_q <= wait_count_t'(hs_ticks_q + 17'h00001);
    end
  end

  a_irq_level: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    irq_out == |(flags_q & enables_q & `EV_MASK))
    else $error("interrupt does not follow flags and enables");

  a_set_beats_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ev_set[`EV_LS] && wr_now && wr_addr_q == `OFS_FLAGS) |=> flags_q[`EV_LS])
    else $error("event lost against a clear");

  a_w1c_clears: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (wr_now && wr_addr_q == `OFS_FLAGS && hwdata_in[`EV_STOP] && !lowspeed_stop_in)
    |=> !flags_q[`EV_STOP])
    else $error("write one did not clear flag");

  a_w0_keeps: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (wr_now && wr_addr_q == `OFS_FLAGS && !hwdata_in[`EV_HS] && flags_q[`EV_HS])
    |=> flags_q[`EV_HS])
    else $error("write zero changed flag");

  a_trim_self_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (trim_finished_in && auto_trim_start_q) |=> (!auto_trim_start_q && flags_q[`EV_TRIM]))
    else $error("trim completion not handled");

  a_ls_gain_mux: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    lowspeed_gain_out == (lowspeed_boost_active_in ? lowspeed_boost_gain_q
                                                   : lowspeed_normal_gain_q))
    else $error("low-speed gain selection wrong");

  a_hs_gain_gate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (highspeed_type_select_out != `HS_TYPE_XTAL) |-> highspeed_xtal_gain_out == 2'h0)
    else $error("crystal gain applied to other type");

  a_ls_settle_flag: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $rose(lowspeed_stable_out) |-> flags_q[`EV_LS] &&
      $past(ls_cnt_q) == wait_count_t'(ls_target(lowspeed_settle_wait_q) - 17'h00001))
    else $error("low-speed settle count wrong");

  a_hs_short_wait: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ($rose(highspeed_stable_out) && highspeed_settle_wait_q == 3'h0)
    |-> hs_ticks_q == `HS_WAIT_BASE)
    else $error("four tick high-speed wait wrong");

  a_reset_flags_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !$past(reset_n_in) |-> !flags_q[`EV_INT])
    else $error("internal settle flag set after reset");

  a_reserved_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    hrdata_out[31:16] == 16'h0000 && (flags_q & ~`EV_MASK) == 6'h00)
    else $error("reserved bits not zero");

  a_ls_short_wait: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ($rose(lowspeed_stable_out) && lowspeed_settle_wait_q == `LS_WAIT_CODE_SHORT)
    |-> ls_ticks_q == `LS_WAIT_4K)
    else $error("low-speed short wait wrong");

  a_stop_sets_flag: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    lowspeed_stop_in |=> flags_q[`EV_STOP])
    else $error("stop event did not set flag");

  a_int_sets_flag: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    internal_settled_in |=> flags_q[`EV_INT])
    else $error("internal settle did not set flag");

endmodule
`default_nettype wire

// ==== osc_analog_model.sv ====
// Purpose: stand-in for the analog oscillator cells
// Assumes: bench commands run and stop, setup block commands trim; ticks on alternate cycles after five cycles
// Notes: internal cell settles 40 cycles after reset; trimming takes 10 cycles
`timescale 1ns/1ps
`default_nettype none
module osc_analog_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // commands from the bench, trim start from the setup block
  input wire logic ls_run_in,
  input wire logic hs_run_in,
  input wire logic stop_req_in,
  input wire logic trim_start_in,
  // cell status
  output logic ls_enable_out,
  output logic ls_tick_out,
  output logic ls_boost_out,
  output logic ls_stop_out,
  output logic hs_enable_out,
  output logic hs_tick_out,
  output logic int_settled_out,
  output logic trim_done_out
);
  logic [15:0] ls_cnt_q;
  logic [15:0] hs_cnt_q;
  logic [5:0] int_cnt_q;
  logic [3:0] trim_cnt_q;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ls_cnt_q <= 16'h0;
      hs_cnt_q <= 16'h0;
      int_cnt_q <= 6'h0;
      trim_cnt_q <= 4'h0;
    end else begin
      ls_cnt_q <= ls_run_in ? ls_cnt_q + 16'h1 : 16'h0;
      hs_cnt_q <= hs_run_in ? hs_cnt_q + 16'h1 : 16'h0;
      int_cnt_q <= int_cnt_q + {5'h0, int_cnt_q < 6'h29};
      trim_cnt_q <= trim_start_in ? trim_cnt_q + {3'h0, trim_cnt_q != 4'hF} : 4'h0;
    end
  end
  assign ls_enable_out = ls_run_in;
  assign ls_tick_out = ls_run_in && ls_cnt_q >= 16'h5 && ls_cnt_q[0];
  // boost startup only for the first cycles of a run
  assign ls_boost_out = ls_run_in && ls_cnt_q < 16'hA;
  assign ls_stop_out = stop_req_in;
  assign hs_enable_out = hs_run_in;
  assign hs_tick_out = hs_run_in && hs_cnt_q >= 16'h5 && hs_cnt_q[0];
  assign int_settled_out = int_cnt_q == 6'h28;
  assign trim_done_out = trim_start_in && trim_cnt_q == 4'hA;
endmodule
`default_nettype wire

// ==== oscillator_setup_and_events_tb.sv ====
// Purpose: self-checking bench for osc_setup_events
// Assumes: short settle parameters 32 and 64
// Notes: bus read data taken at the edge closing the data phase
`timescale 1ns/1ps
`include "osc_setup_defs.svh"
`default_nettype none
module oscillator_setup_and_events_tb;
  import osc_setup_pkg::*;
  logic clock_in = 0, reset_n_in = 0, hsel = 0, hwrite = 0;
  logic ls_run = 0, hs_run = 0, stop_req = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, ls_en, ls_tick, ls_boost, ls_stop, hs_en, hs_tick, int_set, trim_done;
  logic ls_stable, hs_stable, trim_start, irq;
  logic [31:0] hrdata;
  logic [2:0] cap;
  logic [1:0] ls_gain, freq, htype, xgain;
  int fail_count = 0, checks = 0;
  always #2.5 clock_in = ~clock_in;
  osc_setup_events #(.LS_WAIT_MID(17'h00020), .LS_WAIT_LONG(17'h00040),
    .HS_WAIT_MID(17'h00020), .HS_WAIT_LONG(17'h00040)) u_osc_setup_events (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .lowspeed_enable_in(ls_en), .lowspeed_tick_in(ls_tick),
    .lowspeed_boost_active_in(ls_boost), .lowspeed_stop_in(ls_stop),
    .highspeed_enable_in(hs_en), .highspeed_tick_in(hs_tick),
    .internal_settled_in(int_set), .trim_finished_in(trim_done),
    .gate_cap_code_out(cap), .lowspeed_gain_out(ls_gain), .highspeed_freq_select_out(freq),
    .highspeed_type_select_out(htype), .highspeed_xtal_gain_out(xgain),
    .lowspeed_stable_out(ls_stable), .highspeed_stable_out(hs_stable),
    .auto_trim_start_out(trim_start), .irq_out(irq));
  osc_analog_model u_osc_analog_model (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .ls_run_in(ls_run), .hs_run_in(hs_run), .stop_req_in(stop_req),
    .trim_start_in(trim_start), .ls_enable_out(ls_en), .ls_tick_out(ls_tick),
    .ls_boost_out(ls_boost), .ls_stop_out(ls_stop), .hs_enable_out(hs_en),
    .hs_tick_out(hs_tick), .int_settled_out(int_set), .trim_done_out(trim_done));
  task conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task edge_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      fail_count++;
      conclude;
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    edge_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready;
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask
  task settle(input logic ls, input logic [2:0] code, input int n_exp);
    int n;
    int k;
    if (ls)
      wr(`OFS_LS_TUNE, {24'h0, 2'h3, 2'h1, 2'h0, code[1:0]});
    else
      wr(`OFS_HS_SETUP, {20'h0, 4'hE, 2'h0, 2'h2, 1'b0, code});
    @(posedge clock_in);
    if (ls) ls_run <= 1'b1;
    else hs_run <= 1'b1;
    n = 0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clock_in);
      if (ls && k == 2) chk("boost gain out", 32'h3, {30'h0, ls_gain});
      if ((ls ? ls_stable : hs_stable) === 1'b1) break;
      if ((ls ? ls_tick : hs_tick) === 1'b1) n++;
    end
    if (k >= 20000) begin
      fail_count++;
      conclude;
    end
    chk("settle ticks", n_exp, n);
    rdchk("settle flag", `OFS_FLAGS, ls ? 32'h2 : 32'h4);
    wr(`OFS_FLAGS, ls ? 32'h35 : 32'h33);
    rdchk("settle flag kept", `OFS_FLAGS, ls ? 32'h2 : 32'h4);
    wr(`OFS_FLAGS, 32'h37);
    rdchk("flag cleared", `OFS_FLAGS, 32'h0);
    @(posedge clock_in);
    ls_run <= 1'b0;
    hs_run <= 1'b0;
  endtask
  initial begin
    repeat (100000) @(posedge clock_in);
    fail_count++;
    conclude;
  end
  initial begin
    logic [31:0] v, r;
    logic [1:0] b;
    int i;
    void'($urandom(32'h1294));
    repeat (8) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rdchk("ls tune reset", `OFS_LS_TUNE, 32'h92);
    rdchk("hs setup reset", `OFS_HS_SETUP, 32'hC10);
    rdchk("flags reset", `OFS_FLAGS, 32'h0);
    rdchk("enables reset", `OFS_ENABLES, 32'h0);
    for (i = 0; i < 6; i++) begin
      b = 2'($urandom);
      v = ($urandom & 32'h703) | ({30'h0, b} << 6) | (($urandom % ({30'h0, b} + 1)) << 4);
      if (v[1:0] == 2'h0) v[0] = 1'b1;
      wr(`OFS_LS_TUNE, v | 32'hFFFF_F80C);
      rdchk("ls tune", `OFS_LS_TUNE, v);
      chk("cap out", {29'h0, v[10:8]}, {29'h0, cap});
      chk("normal gain out", {30'h0, v[5:4]}, {30'h0, ls_gain});
      r = $urandom & 32'hF37;
      if (r[9:8] == 2'h3) r[8] = 1'b0;
      wr(`OFS_HS_SETUP, r | 32'hFFFF_F0C8);
      rdchk("hs setup", `OFS_HS_SETUP, r);
      chk("freq out", {30'h0, r[11:10]}, {30'h0, freq});
      chk("type out", {30'h0, r[9:8]}, {30'h0, htype});
      chk("xtal gain out", (r[9:8] == 2'h2) ? {30'h0, r[5:4]} : 32'h0, {30'h0, xgain});
      v = $urandom & 32'h37;
      wr(`OFS_ENABLES, v | 32'hFFC8);
      rdchk("enables", `OFS_ENABLES, v);
    end
    wr(8'h20, 32'hFFFF);
    rdchk("unmapped", 8'h20, 32'h0);
    rdchk("clear reg", `OFS_FLAG_CLR, 32'h0);
    wr(`OFS_ENABLES, 32'h0);
    rdchk("internal flag", `OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'h0);
    rdchk("zero write keeps", `OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'h1);
    rdchk("one write clears", `OFS_FLAGS, 32'h0);
    settle(1'b0, 3'h0, 4);
    settle(1'b0, 3'h1, 16);
    settle(1'b0, 3'h2, 64);
    settle(1'b0, 3'h6, 32);
    settle(1'b0, 3'h7, 64);
    settle(1'b1, 3'h1, 4096);
    settle(1'b1, 3'h2, 32);
    settle(1'b1, 3'h3, 64);
    @(posedge clock_in);
    ls_run <= 1'b1;
    i = 0;
    do begin
      bus(1'b0, `OFS_FLAGS, 32'h0, r);
      i++;
    end while (r[1] !== 1'b1 && i < 200);
    chk("ls ready before trim", 32'h1, {31'h0, r[1]});
    wr(`OFS_FLAGS, 32'h37);
    wr(`OFS_ENABLES, 32'h37);
    wr(`OFS_TRIM_CTRL, 32'h10);
    @(negedge clock_in);
    chk("trim start", 32'h1, {31'h0, trim_start});
    for (i = 0; i < 50 && trim_start !== 1'b0; i++) @(negedge clock_in);
    chk("trim finish wait", 32'h0, {31'h0, trim_start});
    rdchk("trim self clear", `OFS_TRIM_CTRL, 32'h0);
    rdchk("trim flag", `OFS_FLAGS, 32'h10);
    chk("irq trim", 32'h1, {31'h0, irq});
    wr(`OFS_ENABLES, 32'h27);
    @(negedge clock_in);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`OFS_ENABLES, 32'h37);
    wr(`OFS_FLAG_CLR, 32'h10);
    @(negedge clock_in);
    chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge clock_in);
    stop_req <= 1'b1;
    @(posedge clock_in);
    stop_req <= 1'b0;
    rdchk("stop flag", `OFS_FLAGS, 32'h20);
    chk("irq stop", 32'h1, {31'h0, irq});
    ls_run <= 1'b0;
    conclude;
  end
endmodule
`default_nettype wire
